/* rtl/sdwl_loader.sv */
// Serial DAC word loader: three-wire shift-in, load pin transfer to DAC register.
//
// Behaviour
// R1 - A write frame carries one 8-bit word of pure data bits, no address or command.
// R2 - Bit 7 of the word is the code MSB and bit 0 is the code LSB.
// R3 - Bits arrive MSB first: the first sampled bit is bit 7, the eighth is bit 0.
// R4 - A falling edge of the frame select opens a frame and arms the shift register.
// R5 - Data shifts in only while the frame select is low; activity while high is ignored.
// R6 - The host lowers frame select ahead of the first serial clock falling edge.
// R7 - The host raises frame select after eight bits to close the frame.
// R8 - Driving the load input low after a complete word copies it to the DAC register.
// R9 - The host may hold the load input permanently low.
// R10 - After frame select rises no data is taken until its next falling edge.
// R11 - The DAC register holds an 8-bit unsigned code that sets the output level.
// R12 - Serial data is sampled on each of the first eight serial clock falling edges of an open frame.
// R13 - With load held low the DAC register updates on the eighth falling edge.
// R14 - A frame closed before eight bits is discarded and the DAC register kept.
`timescale 1ns/1ns
module sdwl_loader #(
    parameter int WORD_BITS = sdwl_pkg::WORD_BITS
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire sdwl_pkg::sdwl_pins_t   pins,
    output logic [WORD_BITS-1:0]        dac_code,
    output logic                        word_ready,
    output logic                        frame_open
);

    // ************************************************************
    // State record
    // ************************************************************
    typedef struct packed {
        sdwl_pkg::sdwl_pins_t  sync1;
        sdwl_pkg::sdwl_pins_t  sync2;
        logic                  sclk_prev;
        logic                  fsel_prev;
        logic                  load_converter_n_prev;
        sdwl_pkg::sdwl_state_t state;
        logic [3:0]            bit_count;
        logic [WORD_BITS-1:0]  shift_word;
        logic [WORD_BITS-1:0]  dac_reg;
    } sdwl_regs_t;

    sdwl_regs_t r;
    sdwl_regs_t next_r;

    // ************************************************************
    // Local constants
    // ************************************************************
    // Count value on the edge that takes the final bit of a word
    localparam logic [3:0] LAST_COUNT = sdwl_pkg::BIT_COUNT_FULL - sdwl_pkg::BIT_COUNT_ONE;

    // ************************************************************
    // Helper functions
    // ************************************************************
    // One-cycle pulse where a synchronised level goes from 1 to 0
    function automatic logic level_fell(
        input logic prev_level,
        input logic cur_level
    );
        level_fell = prev_level & ~cur_level;
    endfunction

    // One-cycle pulse where a synchronised level goes from 0 to 1
    function automatic logic level_rose(
        input logic prev_level,
        input logic cur_level
    );
        level_rose = ~prev_level & cur_level;
    endfunction

    // MSB first: older bits move up, the new bit enters at the bottom
    function automatic logic [WORD_BITS-1:0] shift_in(
        input logic [WORD_BITS-1:0] word,
        input logic                 bit_in
    );
        shift_in = {word[WORD_BITS-2:0], bit_in};
    endfunction

    // True on the count at which the final bit of a word is taken
    function automatic logic is_last_bit(
        input logic [3:0] count
    );
        is_last_bit = (count == LAST_COUNT);
    endfunction

    // Fresh frame: empty shift register, count from zero
    function automatic sdwl_regs_t arm_frame(
        input sdwl_regs_t cur
    );
        sdwl_regs_t armed;
        armed            = cur;
        armed.state      = sdwl_pkg::SDWL_SHIFT;
        armed.bit_count  = sdwl_pkg::BIT_COUNT_ZERO;
        armed.shift_word = sdwl_pkg::SHIFT_RESET;
        arm_frame        = armed;
    endfunction

    // Reset record: pin stages and edge history idle high, so no false edge after reset
    function automatic sdwl_regs_t reset_regs();
        sdwl_regs_t init;
        init.sync1      = '1;
        init.sync2      = '1;
        init.sclk_prev  = 1'b1;
        init.fsel_prev  = 1'b1;
        init.load_converter_n_prev  = 1'b1;
        init.state      = sdwl_pkg::SDWL_IDLE;
        init.bit_count  = sdwl_pkg::BIT_COUNT_ZERO;
        init.shift_word = sdwl_pkg::SHIFT_RESET;
        init.dac_reg    = sdwl_pkg::CODE_RESET;
        reset_regs      = init;
    endfunction

    logic sclk_fall;
    logic fsel_fall;
    logic fsel_rise;
    logic load_converter_n_low;
    logic load_converter_n_fall;
    logic take_bit;
    logic word_done;
    logic auto_load;
    logic pin_load;

    // ************************************************************
    // Edge detection on synchronised pins
    // ************************************************************
    // Edges come from the second stage only; first stage feeds nothing else
    assign sclk_fall = level_fell(r.sclk_prev, r.sync2.serial_clock);
    assign fsel_fall = level_fell(r.fsel_prev, r.sync2.frame_select_n);
    assign fsel_rise = level_rose(r.fsel_prev, r.sync2.frame_select_n);
    // Load level picks auto mode; its fall is the explicit copy
    assign load_converter_n_low  = ~r.sync2.load_converter_n;
    assign load_converter_n_fall = level_fell(r.load_converter_n_prev, r.sync2.load_converter_n);

    // ************************************************************
    // Transfer decisions
    // ************************************************************
    // R12 bit taken on serial clock fall
    assign take_bit  = (r.state == sdwl_pkg::SDWL_SHIFT) && !fsel_rise && sclk_fall;
    // R1 word complete on last bit
    assign word_done = take_bit && is_last_bit(r.bit_count);
    // R13 auto update, load held low
    assign auto_load = word_done && load_converter_n_low;
    // R8 load fall after complete word
    assign pin_load  = (r.state == sdwl_pkg::SDWL_FULL) && load_converter_n_fall;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_r           = r;
        next_r.sync1     = pins;
        next_r.sync2     = r.sync1;
        next_r.sclk_prev = r.sync2.serial_clock;
        next_r.fsel_prev = r.sync2.frame_select_n;
        next_r.load_converter_n_prev = r.sync2.load_converter_n;

        unique case (r.state)
            sdwl_pkg::SDWL_IDLE: begin
                // R5 clocks ignored while closed
                // R4 falling edge arms
                if (fsel_fall) begin
                    next_r = arm_frame(next_r);
                end
            end
            sdwl_pkg::SDWL_SHIFT: begin
                if (fsel_rise) begin
                    // R14 partial word dropped
                    next_r.state = sdwl_pkg::SDWL_IDLE;
                end else if (take_bit) begin
                    // R12 R3 R2 MSB first shift
                    next_r.shift_word = shift_in(r.shift_word, r.sync2.serial_data_in);
                    next_r.bit_count  = r.bit_count + sdwl_pkg::BIT_COUNT_ONE;
                    // R1 one word per frame
                    if (word_done) begin
                        next_r.state = sdwl_pkg::SDWL_FULL;
                    end
                end
            end
            sdwl_pkg::SDWL_FULL: begin
                // R10 R5 further clocks ignored; wait for next frame
                if (fsel_fall) begin
                    next_r = arm_frame(next_r);
                end
            end
            default: begin
                next_r.state = sdwl_pkg::SDWL_IDLE;
            end
        endcase

        // Never both at once: auto load needs SHIFT, pin load needs FULL
        // R13 auto update on eighth edge
        if (auto_load) begin
            next_r.dac_reg = shift_in(r.shift_word, r.sync2.serial_data_in);
        end
        // R8 load pin falling copies complete word
        if (pin_load) begin
            next_r.dac_reg = r.shift_word;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        // One record holds every idle level
        if (rst) begin
            r <= reset_regs();
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Status decodes the state flops directly
    // R11 unsigned code out
    assign dac_code   = r.dac_reg;
    assign word_ready = (r.state == sdwl_pkg::SDWL_FULL);
    assign frame_open = (r.state == sdwl_pkg::SDWL_SHIFT);

endmodule

/* rtl/sdwl_pkg.sv */
// Package for the serial DAC word loader: widths, reset values, structs.
package sdwl_pkg;
    localparam int            WORD_BITS      = 8;
    localparam logic [3:0]    BIT_COUNT_ZERO = 4'h0;
    localparam logic [3:0]    BIT_COUNT_ONE  = 4'h1;
    localparam logic [3:0]    BIT_COUNT_FULL = 4'h8;
    localparam logic [7:0]    CODE_RESET     = 8'h00;
    localparam logic [7:0]    SHIFT_RESET    = 8'h00;
    localparam int            MSB_POS        = 7;
    localparam int            LSB_POS        = 0;

    // Host-side serial pins, all asynchronous to ref_clk
    typedef struct packed {
        logic frame_select_n;
        logic serial_clock;
        logic serial_data_in;
        logic load_converter_n;
    } sdwl_pins_t;

    typedef enum logic [1:0] {
        SDWL_IDLE,
        SDWL_SHIFT,
        SDWL_FULL
    } sdwl_state_t;
endpackage

/* tb/sdwl_host_model.sv */
// Host model: frames words onto select, serial clock and data pins.
`timescale 1ns/1ns
module sdwl_host_model (
    input  wire logic            ref_clk,
    output sdwl_pkg::sdwl_pins_t pins
);
    initial pins = 4'hF;
    task automatic set_load(input logic level);
        pins.load_converter_n = level;
    endtask
    task automatic frame(input logic [9:0] w, input int n, input logic sel);
        pins.frame_select_n = ~sel;
        repeat (8) @(negedge ref_clk);
        for (int i = 9; i > 9 - n; i--) begin
            pins.serial_clock = 1'b1;
            pins.serial_data_in = w[i];
            repeat (8) @(negedge ref_clk);
            pins.serial_clock = 1'b0;
            repeat (8) @(negedge ref_clk);
        end
        pins.serial_clock = 1'b1;
        pins.frame_select_n = 1'b1;
        pins.serial_data_in = ~pins.serial_data_in;
        repeat (8) @(negedge ref_clk);
    endtask
endmodule

/* tb/sdwl_loader_asserts.sv */
// Checker: port-level properties of the serial word loader.
`timescale 1ns/1ns
module sdwl_loader_asserts #(parameter int WORD_BITS = 8) (
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire sdwl_pkg::sdwl_pins_t pins,
    input wire logic [WORD_BITS-1:0] dac_code,
    input wire logic                 word_ready,
    input wire logic                 frame_open
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_reset_clear: assert property ($fell(rst) |-> dac_code == '0 && !word_ready)
        else $error("reset state");
    chk_idle_quiet: assert property (pins.frame_select_n [*6] |-> !frame_open)
        else $error("frame open while deselected");
    chk_frame_opens: assert property ($fell(pins.frame_select_n) |-> ##[2:5] frame_open)
        else $error("frame did not open");
    chk_open_cause: assert property ($rose(frame_open) |-> !$past(pins.frame_select_n, 2))
        else $error("frame opened without select");
    chk_code_guard: assert property (!$stable(dac_code) |-> word_ready)
        else $error("code changed without word");
    chk_ready_shut: assert property ($rose(word_ready) |-> $past(frame_open) && !frame_open)
        else $error("word ready out of frame");
    chk_ready_hold: assert property ((word_ready && pins.frame_select_n) [*5] |=> word_ready)
        else $error("word ready dropped");
    chk_partial_drop: assert property ($fell(frame_open) && !word_ready |-> $stable(dac_code))
        else $error("partial word reached the code");
endmodule
bind sdwl_loader sdwl_loader_asserts #(.WORD_BITS(WORD_BITS)) i_sdwl_loader_asserts (
    .ref_clk(ref_clk), .rst(rst), .pins(pins), .dac_code(dac_code),
    .word_ready(word_ready), .frame_open(frame_open));

/* tb/sdwl_loader_tb_top.sv */
// Testbench: host model drives the loader, a queue predicts the code.
`timescale 1ns/1ns
module sdwl_loader_tb_top;
    logic                 ref_clk = 1'b0;
    logic                 rst = 1'b1;
    sdwl_pkg::sdwl_pins_t pins;
    logic [7:0]           dac_code, exp_code = 8'h00;
    logic                 word_ready, frame_open;
    logic [9:0]           w;
    logic [7:0]           q[$];
    int                   bad_count = 0, samples_checked = 0, n;
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    sdwl_host_model i_sdwl_host_model (.ref_clk(ref_clk), .pins(pins));
    sdwl_loader i_sdwl_loader (.ref_clk(ref_clk), .rst(rst), .pins(pins),
        .dac_code(dac_code), .word_ready(word_ready), .frame_open(frame_open));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'hF4B6));
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        check(dac_code, 8'h00);
        for (int i = 0; i < 16; i++) begin
            w = 10'($urandom);
            n = (i % 4 == 2) ? 5 : (i % 4 == 3) ? 10 : 8;
            // load held low in auto passes
            i_sdwl_host_model.set_load(i % 4 != 1);
            i_sdwl_host_model.frame(w, n, i != 7);
            if (i != 7 && n >= 8) begin
                q.push_back(w[9:2]);
            end
            if (i % 4 == 1) begin
                exp_code = q.pop_back();
            end
            check({7'h00, word_ready}, {7'h00, i != 7 && n >= 8});
            check({7'h00, frame_open}, 8'h00);
            check(dac_code, exp_code);
            i_sdwl_host_model.set_load(1'b0);
            repeat (8) @(negedge ref_clk);
            if (q.size() > 0) begin
                exp_code = q.pop_front();
            end
            check(dac_code, exp_code);
        end
        report_and_stop();
    end
endmodule
